// File: common/bpfs_defs.svh
`ifndef BPFS_DEFS_SVH
`define BPFS_DEFS_SVH

// ***************************************************************
// Boot modes
// ***************************************************************
`define BPFS_BOOT_PARALLEL      2'h0
`define BPFS_BOOT_SERIAL_FAST   2'h1
`define BPFS_BOOT_NAND          2'h2
`define BPFS_BOOT_SERIAL_SLOW   2'h3

// ***************************************************************
// Function codes and field widths
// ***************************************************************
`define BPFS_PF_FIELD_W         3
`define BPFS_PD_FIELD_W         2
`define BPFS_PF_CODE_GPIO       3'h0
`define BPFS_PF_CODE_SERIAL     3'h3
`define BPFS_PF_CODE_NAND       3'h5
`define BPFS_PD_CODE_GPIO       2'h0
`define BPFS_PD_CODE_NAND       2'h1
`define BPFS_PD_CODE_DATA       2'h2

// ***************************************************************
// Bus widths and boot sizes
// ***************************************************************
`define BPFS_AREA0_DATA_W       16
`define BPFS_BOOT_ADDR_HI       20
`define BPFS_ADDR_W             26
`define BPFS_LOADER_BYTES       8192
`define BPFS_ECC_MAX_SYMBOLS    4

`endif

// File: common/bpfs_pkg.sv
package bpfs_pkg;

    // Shared memory-side pin owner
    typedef enum logic [1:0] {
        BPFS_OWN_GPIO,
        BPFS_OWN_BUS,
        BPFS_OWN_NAND
    } bpfs_owner_t;

    // Per-pin drive bundle
    typedef struct packed {
        logic out;
        logic oe_n;
    } bpfs_pin_t;

    // NAND controller strobes and data
    typedef struct packed {
        logic       chip_enable_n;
        logic       write_strobe_n;
        logic       read_strobe_n;
        logic       address_latch;
        logic       command_latch;
        logic [7:0] data_out;
        logic       data_oe;
    } bpfs_nand_t;

    // Serial peripheral outputs
    typedef struct packed {
        logic transmit_data;
        logic slave_select_n;
        logic clock_out;
    } bpfs_serial_t;

endpackage

// File: rtl/bpfs_portf_mux.sv
`timescale 1ns/100ps
`default_nettype none
`include "bpfs_defs.svh"

// ***************************************************************
// Port F pin 9..12 function routing
// ***************************************************************
module bpfs_portf_mux (
    // Function fields
    input  wire logic [2:0]                portf_pin12_function_i,
    input  wire logic [2:0]                portf_pin11_function_i,
    input  wire logic [2:0]                portf_pin10_function_i,
    input  wire logic [2:0]                portf_pin9_function_i,
    // Peripheral sources
    input  wire bpfs_pkg::bpfs_serial_t    serial_i,
    input  wire logic                      nand_chip_enable_n_i,
    input  wire logic [3:0]                gpio_out_i,
    input  wire logic [3:0]                gpio_oe_n_i,
    // Pin drive
    output logic [3:0]                     pin_out_o,
    output logic [3:0]                     pin_oe_n_o,
    output logic                           serial_sel_o,
    output logic                           nand_rb_sel_o
);

    // Code match helper
    function automatic logic is_code(input logic [2:0] f, input logic [2:0] c);
        is_code = (f == c);
    endfunction

    // Per-pin selection; unknown codes stay GPIO
    always_comb begin
        pin_out_o  = gpio_out_i;
        pin_oe_n_o = gpio_oe_n_i;
        // Pin 12 receive data: input only in serial mode
        if (is_code(portf_pin12_function_i, `BPFS_PF_CODE_SERIAL)) begin
            pin_out_o[3]  = 1'b0;
            pin_oe_n_o[3] = 1'b1;
        end
        if (is_code(portf_pin11_function_i, `BPFS_PF_CODE_SERIAL)) begin
            pin_out_o[2]  = serial_i.transmit_data;
            pin_oe_n_o[2] = 1'b0;
        end
        if (is_code(portf_pin10_function_i, `BPFS_PF_CODE_SERIAL)) begin
            pin_out_o[1]  = serial_i.slave_select_n;
            pin_oe_n_o[1] = 1'b0;
        end else if (is_code(portf_pin10_function_i, `BPFS_PF_CODE_NAND)) begin
            pin_out_o[1]  = nand_chip_enable_n_i;
            pin_oe_n_o[1] = 1'b0;
        end
        if (is_code(portf_pin9_function_i, `BPFS_PF_CODE_SERIAL)) begin
            pin_out_o[0]  = serial_i.clock_out;
            pin_oe_n_o[0] = 1'b0;
        end else if (is_code(portf_pin9_function_i, `BPFS_PF_CODE_NAND)) begin
            pin_out_o[0]  = 1'b0;                         // Ready/busy is an input
            pin_oe_n_o[0] = 1'b1;
        end
    end

    // Selection flags for receive path
    assign serial_sel_o  = is_code(portf_pin12_function_i, `BPFS_PF_CODE_SERIAL);
    assign nand_rb_sel_o = is_code(portf_pin9_function_i, `BPFS_PF_CODE_NAND);

endmodule
`default_nettype wire

// File: rtl/bpfs_portd_mux.sv
`timescale 1ns/100ps
`default_nettype none
`include "bpfs_defs.svh"

// ***************************************************************
// Port D pin 4..15 owner selection
// ***************************************************************
module bpfs_portd_mux #(
    parameter int PINS = 12
) (
    // Function fields, two bits per pin
    input  wire logic [2*PINS-1:0]   fields_i,
    // Live owner request from the NAND chip enable
    input  wire logic                nand_active_i,
    // Per-pin owner
    output var bpfs_pkg::bpfs_owner_t owner_o [PINS]
);

    // Owner for one pin; NAND-capable pins hand over automatically
    function automatic bpfs_pkg::bpfs_owner_t pick(input logic [1:0] f, input logic nand_act);
        if (f == `BPFS_PD_CODE_NAND) begin
            pick = nand_act ? bpfs_pkg::BPFS_OWN_NAND : bpfs_pkg::BPFS_OWN_BUS;
        end else if (f == `BPFS_PD_CODE_DATA) begin
            pick = bpfs_pkg::BPFS_OWN_BUS;
        end else begin
            pick = bpfs_pkg::BPFS_OWN_GPIO;
        end
    endfunction

    // One owner per pin
    always_comb begin
        for (int i = 0; i < PINS; i++) begin
            owner_o[i] = pick(fields_i[2*i +: 2], nand_active_i);
        end
    end

endmodule
`default_nettype wire

// File: rtl/bpfs_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "bpfs_defs.svh"

// ***************************************************************
// Boot pin function select, top level
// ***************************************************************
module bpfs_top #(
    parameter int ADDR_W  = `BPFS_ADDR_W,
    parameter int BOOT_HI = `BPFS_BOOT_ADDR_HI
) (
    // Clock, reset, enable
    input  wire logic                 clk_i,
    input  wire logic                 resetn_i,
    input  wire logic                 ce_i,
    // Boot straps
    input  wire logic                 boot_select_low_bit_i,
    input  wire logic                 boot_select_high_bit_i,
    // Software function fields and bus setup
    input  wire logic                 func_write_i,
    input  wire logic [2:0]           portf_pin12_function_i,
    input  wire logic [2:0]           portf_pin11_function_i,
    input  wire logic [2:0]           portf_pin10_function_i,
    input  wire logic [2:0]           portf_pin9_function_i,
    input  wire logic [23:0]          portd_function_i,
    input  wire logic                 bus_unit_ready_i,
    input  wire logic                 upper_addr_enable_i,
    input  wire logic                 loader_serial_done_i,
    // Bus unit request
    input  wire logic [ADDR_W-1:0]    bus_addr_i,
    input  wire logic [15:0]          bus_wdata_i,
    input  wire logic                 bus_read_i,
    input  wire logic                 bus_write_i,
    // NAND controller and serial sources
    input  wire bpfs_pkg::bpfs_nand_t nand_i,
    input  wire logic                 nand_cmd_req_i,
    input  wire bpfs_pkg::bpfs_serial_t serial_i,
    input  wire logic [3:0]           portf_gpio_out_i,
    input  wire logic [3:0]           portf_gpio_oe_n_i,
    input  wire logic [11:0]          portd_gpio_out_i,
    input  wire logic [11:0]          portd_gpio_oe_n_i,
    // Pin inputs
    input  wire logic [3:0]           portf_pin_in_i,
    // Memory pins
    output logic [ADDR_W-1:1]         addr_o,
    output logic [ADDR_W-1:1]         addr_oe_n_o,
    output logic [15:0]               data_out_o,
    output logic [15:0]               data_oe_n_o,
    output logic                      read_strobe_n_o,
    output logic                      area0_chip_select_n_o,
    output logic                      area0_chip_select_oe_n_o,
    output logic                      lane0_write_strobe_n_o,
    output logic                      lane0_write_strobe_oe_n_o,
    output logic [15:4]               portd_out_o,
    output logic [15:4]               portd_oe_n_o,
    output logic [3:0]                portf_out_o,
    output logic [3:0]                portf_oe_n_o,
    // Status
    output logic [1:0]                boot_mode_o,
    output logic                      boot_serial_o,
    output logic                      boot_nand_o,
    output logic                      nand_cmd_grant_o,
    output logic                      serial_receive_data_o,
    output logic                      nand_ready_busy_o
);

    // ***************************************************************
    // Configuration state
    // ***************************************************************
    logic [1:0]  mode_reg,    mode_next;
    logic        strap_reg,   strap_next;
    logic [2:0]  pf12_reg,    pf12_next;
    logic [2:0]  pf11_reg,    pf11_next;
    logic [2:0]  pf10_reg,    pf10_next;
    logic [2:0]  pf9_reg,     pf9_next;
    logic [23:0] pd_reg,      pd_next;
    logic        bsu_reg,     bsu_next;
    logic        upper_reg,   upper_next;

    // Defaults per boot mode for port D fields
    function automatic logic [23:0] pd_default(input logic [1:0] m);
        pd_default = (m == `BPFS_BOOT_PARALLEL) ? {24{1'b0}} | {12{`BPFS_PD_CODE_DATA}}
                                                : {12{`BPFS_PD_CODE_GPIO}};
    endfunction

    // Next configuration: strap caught once after reset release
    always_comb begin
        mode_next  = mode_reg;
        strap_next = strap_reg;
        pf12_next  = pf12_reg;
        pf11_next  = pf11_reg;
        pf10_next  = pf10_reg;
        pf9_next   = pf9_reg;
        pd_next    = pd_reg;
        bsu_next   = bsu_reg | bus_unit_ready_i;
        upper_next = upper_reg;
        if (!strap_reg) begin
            strap_next = 1'b1;
            mode_next  = {boot_select_high_bit_i, boot_select_low_bit_i};
            pd_next    = pd_default({boot_select_high_bit_i, boot_select_low_bit_i});
        end else if (func_write_i) begin
            pf12_next = portf_pin12_function_i;
            pf11_next = portf_pin11_function_i;
            pf10_next = portf_pin10_function_i;
            pf9_next  = portf_pin9_function_i;
            pd_next   = portd_function_i;
        end else if (loader_serial_done_i && (mode_reg == `BPFS_BOOT_SERIAL_FAST
                                           || mode_reg == `BPFS_BOOT_SERIAL_SLOW)) begin
            // Boot loader sets serial functions itself
            pf12_next = `BPFS_PF_CODE_SERIAL;
            pf11_next = `BPFS_PF_CODE_SERIAL;
            pf10_next = `BPFS_PF_CODE_SERIAL;
            pf9_next  = `BPFS_PF_CODE_SERIAL;
        end
        if (bsu_reg && upper_addr_enable_i) begin
            upper_next = 1'b1;
        end
    end

    // Register configuration
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            mode_reg  <= 2'h0;
            strap_reg <= 1'b0;
            pf12_reg  <= `BPFS_PF_CODE_GPIO;
            pf11_reg  <= `BPFS_PF_CODE_GPIO;
            pf10_reg  <= `BPFS_PF_CODE_GPIO;
            pf9_reg   <= `BPFS_PF_CODE_GPIO;
            pd_reg    <= {12{`BPFS_PD_CODE_GPIO}};
            bsu_reg   <= 1'b0;
            upper_reg <= 1'b0;
        end else if (ce_i) begin
            mode_reg  <= mode_next;
            strap_reg <= strap_next;
            pf12_reg  <= pf12_next;
            pf11_reg  <= pf11_next;
            pf10_reg  <= pf10_next;
            pf9_reg   <= pf9_next;
            pd_reg    <= pd_next;
            bsu_reg   <= bsu_next;
            upper_reg <= upper_next;
        end
    end

    // ***************************************************************
    // Pin routing
    // ***************************************************************
    logic [3:0]            pf_out, pf_oe_n;
    logic                  serial_sel, rb_sel;
    bpfs_pkg::bpfs_owner_t owner [12];
    logic                  nand_act;
    logic                  rb_level;

    // NAND owns the shared pins set to the NAND code whenever its chip enable is low
    assign nand_act = ~nand_i.chip_enable_n;
    // Busy input: reads as ready unless pin 9 has the NAND function
    assign rb_level = rb_sel ? portf_pin_in_i[0] : 1'b1;

    bpfs_portf_mux u_portf (
        .portf_pin12_function_i (pf12_reg),
        .portf_pin11_function_i (pf11_reg),
        .portf_pin10_function_i (pf10_reg),
        .portf_pin9_function_i  (pf9_reg),
        .serial_i               (serial_i),
        .nand_chip_enable_n_i   (nand_i.chip_enable_n),
        .gpio_out_i             (portf_gpio_out_i),
        .gpio_oe_n_i            (portf_gpio_oe_n_i),
        .pin_out_o              (pf_out),
        .pin_oe_n_o             (pf_oe_n),
        .serial_sel_o           (serial_sel),
        .nand_rb_sel_o          (rb_sel)
    );

    bpfs_portd_mux #(.PINS(12)) u_portd (
        .fields_i      (pd_reg),
        .nand_active_i (nand_act),
        .owner_o       (owner)
    );

    // ***************************************************************
    // Pin drive computation
    // ***************************************************************
    logic [ADDR_W-1:1] addr_next, addr_oe_n_next;
    logic [15:0]       dout_next, doe_n_next;
    logic [15:4]       pd_out_next, pd_oe_n_next;
    logic              rd_next, cs_next, we_next, we_oe_n_next;
    logic [11:0]       nand_pin_out;

    // Per-pin NAND function: pins 4..7 strobes, 8..15 data
    always_comb begin
        nand_pin_out = {nand_i.data_out, nand_i.write_strobe_n, nand_i.address_latch,
                        nand_i.command_latch, nand_i.read_strobe_n};
    end

    // Bus unit and shared pin drive
    always_comb begin
        // Area 0 is 16 bits wide; width not selectable
        dout_next  = bus_wdata_i[`BPFS_AREA0_DATA_W-1:0];
        doe_n_next = {16{~bus_write_i}};
        for (int a = 1; a < ADDR_W; a++) begin
            addr_next[a]      = bus_addr_i[a];
            // Only A1..A20 drive until upper lines are enabled
            addr_oe_n_next[a] = (a > BOOT_HI) ? ~upper_reg : 1'b0;
        end
        rd_next      = ~bus_read_i;
        cs_next      = ~(bus_read_i | bus_write_i);
        // Write strobe stays GPIO input until bus unit set
        we_next      = bsu_reg ? ~bus_write_i : 1'b1;
        we_oe_n_next = ~bsu_reg;
        for (int p = 0; p < 12; p++) begin
            unique case (owner[p])
                bpfs_pkg::BPFS_OWN_NAND: begin
                    pd_out_next[p+4]  = nand_pin_out[p];
                    pd_oe_n_next[p+4] = (p >= 4) ? ~nand_i.data_oe : 1'b0;
                end
                bpfs_pkg::BPFS_OWN_BUS: begin
                    pd_out_next[p+4]  = bus_wdata_i[p+4];
                    pd_oe_n_next[p+4] = ~bus_write_i;
                end
                default: begin
                    pd_out_next[p+4]  = portd_gpio_out_i[p];
                    pd_oe_n_next[p+4] = portd_gpio_oe_n_i[p];
                end
            endcase
        end
    end

    // Register every pin output
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            addr_o                    <= '0;
            addr_oe_n_o               <= '1;
            data_out_o                <= 16'h0000;
            data_oe_n_o               <= 16'hffff;
            read_strobe_n_o           <= 1'b1;
            area0_chip_select_n_o     <= 1'b1;
            area0_chip_select_oe_n_o  <= 1'b1;
            lane0_write_strobe_n_o    <= 1'b1;
            lane0_write_strobe_oe_n_o <= 1'b1;
            portd_out_o               <= 12'h000;
            portd_oe_n_o              <= 12'hfff;
            portf_out_o               <= 4'h0;
            portf_oe_n_o              <= 4'hf;
            boot_mode_o               <= 2'h0;
            boot_serial_o             <= 1'b0;
            boot_nand_o               <= 1'b0;
            nand_cmd_grant_o          <= 1'b0;
            serial_receive_data_o     <= 1'b0;
            nand_ready_busy_o         <= 1'b1;
        end else if (ce_i) begin
            addr_o                    <= addr_next;
            addr_oe_n_o               <= strap_reg ? addr_oe_n_next : '1;
            data_out_o                <= dout_next;
            data_oe_n_o               <= doe_n_next;
            read_strobe_n_o           <= rd_next;
            area0_chip_select_n_o     <= cs_next;
            area0_chip_select_oe_n_o  <= ~(strap_reg && mode_reg == `BPFS_BOOT_PARALLEL);
            lane0_write_strobe_n_o    <= we_next;
            lane0_write_strobe_oe_n_o <= we_oe_n_next;
            portd_out_o               <= pd_out_next;
            portd_oe_n_o              <= pd_oe_n_next;
            portf_out_o               <= pf_out;
            portf_oe_n_o              <= pf_oe_n;
            boot_mode_o               <= mode_reg;
            boot_serial_o             <= strap_reg & mode_reg[0];
            boot_nand_o               <= strap_reg & (mode_reg == `BPFS_BOOT_NAND);
            nand_cmd_grant_o          <= nand_cmd_req_i & rb_level;
            serial_receive_data_o     <= serial_sel ? portf_pin_in_i[3] : 1'b0;
            nand_ready_busy_o         <= rb_level;
        end
    end

    // ***************************************************************
    // Checks
    // ***************************************************************
    chk_busy_no_cmd: assert property (@(posedge clk_i) disable iff (!resetn_i)
        ce_i && rb_sel && !portf_pin_in_i[0] |=> !nand_cmd_grant_o)
        else $error("NAND command granted while busy");
    chk_upper_addr_off: assert property (@(posedge clk_i) disable iff (!resetn_i)
        !upper_reg |-> addr_oe_n_o[ADDR_W-1])
        else $error("upper address driven before enable");
    chk_we_gpio_input: assert property (@(posedge clk_i) disable iff (!resetn_i)
        !bsu_reg && $past(!bsu_reg) |-> lane0_write_strobe_oe_n_o)
        else $error("write strobe driven before setup");
    chk_pf_serial_sel: assert property (@(posedge clk_i) disable iff (!resetn_i)
        ce_i && pf11_reg == `BPFS_PF_CODE_SERIAL |=> !portf_oe_n_o[2])
        else $error("serial transmit not driven");
    chk_pf_nand_ce: assert property (@(posedge clk_i) disable iff (!resetn_i)
        ce_i && pf10_reg == `BPFS_PF_CODE_NAND |=> portf_out_o[1] == $past(nand_i.chip_enable_n))
        else $error("NAND chip enable not routed");
    chk_pd_unknown: assert property (@(posedge clk_i) disable iff (!resetn_i)
        ce_i && pd_reg[23:22] == 2'h3 |=> portd_oe_n_o[15] == $past(portd_gpio_oe_n_i[11]))
        else $error("unknown code drove memory signal");
    chk_mode_nand: assert property (@(posedge clk_i) disable iff (!resetn_i)
        ce_i && strap_reg && mode_reg == `BPFS_BOOT_NAND |=> boot_nand_o && !boot_serial_o)
        else $error("NAND boot flag wrong");
    chk_cs_parallel: assert property (@(posedge clk_i) disable iff (!resetn_i)
        ce_i && strap_reg && mode_reg != `BPFS_BOOT_PARALLEL |=> area0_chip_select_oe_n_o)
        else $error("area 0 select driven outside mode 0");

endmodule
`default_nettype wire

// File: verification/bpfs_flash_model.sv
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// Flash side of the port F pins
// ****************************************
module bpfs_flash_model (
    // Device pin drive
    input  wire logic [3:0] out_i,
    input  wire logic [3:0] oe_n_i,
    // Bench control
    input  wire logic       busy_i,
    // Levels seen by the device
    output logic [3:0]      pin_o
);
    // Pull-up holds ready high unless the flash is busy
    assign pin_o[0] = busy_i ? 1'b0 : 1'b1;
    assign pin_o[2:1] = 2'h3;
    // Inverted echo, so a stale receive level cannot pass
    assign pin_o[3] = oe_n_i[2] ? 1'b1 : ~out_i[2];
endmodule
`default_nettype wire

// File: verification/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// Boot pin select bench
// ****************************************
module tb_top;
    logic clk_i = 1'b0, resetn_i = 1'b0, bl = 1'b0, bh = 1'b0, fw = 1'b0, bur = 1'b0, uae = 1'b0;
    logic lsd = 1'b0, rd = 1'b0, wr = 1'b0, creq = 1'b0, busy = 1'b0;
    logic [2:0] f12 = 3'h0, f11 = 3'h0, f10 = 3'h0, f9 = 3'h0;
    logic [23:0] pdf = 24'h000000;
    logic [15:0] bw = 16'h0000;
    logic [25:0] ba = 26'h0000000;
    bpfs_pkg::bpfs_nand_t nd = '0;
    bpfs_pkg::bpfs_serial_t sr = 3'h0;
    logic [3:0] fgo = 4'h0, fgoe = 4'hf, pin, pfo, pfoe;
    logic [11:0] dgo = 12'h000, dgoe = 12'hfff;
    logic [25:1] ao, aoe;
    logic [15:0] dout, doe;
    logic [15:4] pdo, pdoe;
    logic [1:0] bm;
    logic rsn, cs, csoe, we, weoe, bs, bn, gr, srd, rb;
    int miscompares = 0, checked = 0;
    // Free-running 200 MHz clock
    always #2.5 clk_i = ~clk_i;
    bpfs_top DUT (.clk_i(clk_i), .resetn_i(resetn_i), .ce_i(1'b1), .boot_select_low_bit_i(bl),
        .boot_select_high_bit_i(bh), .func_write_i(fw), .portf_pin12_function_i(f12),
        .portf_pin11_function_i(f11), .portf_pin10_function_i(f10), .portf_pin9_function_i(f9),
        .portd_function_i(pdf), .bus_unit_ready_i(bur), .upper_addr_enable_i(uae),
        .loader_serial_done_i(lsd), .bus_addr_i(ba), .bus_wdata_i(bw), .bus_read_i(rd),
        .bus_write_i(wr), .nand_i(nd), .nand_cmd_req_i(creq), .serial_i(sr), .portf_gpio_out_i(fgo),
        .portf_gpio_oe_n_i(fgoe), .portd_gpio_out_i(dgo), .portd_gpio_oe_n_i(dgoe), .portf_pin_in_i(pin),
        .addr_o(ao), .addr_oe_n_o(aoe), .data_out_o(dout), .data_oe_n_o(doe), .read_strobe_n_o(rsn),
        .area0_chip_select_n_o(cs), .area0_chip_select_oe_n_o(csoe), .lane0_write_strobe_n_o(we),
        .lane0_write_strobe_oe_n_o(weoe), .portd_out_o(pdo), .portd_oe_n_o(pdoe), .portf_out_o(pfo),
        .portf_oe_n_o(pfoe), .boot_mode_o(bm), .boot_serial_o(bs), .boot_nand_o(bn),
        .nand_cmd_grant_o(gr), .serial_receive_data_o(srd), .nand_ready_busy_o(rb));
    bpfs_flash_model FLASH (.out_i(pfo), .oe_n_i(pfoe), .busy_i(busy), .pin_o(pin));
    task automatic check(input logic [31:0] s, input logic [31:0] e);
        checked++;
        if (s !== e) begin
            miscompares++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk_i);
    endtask
    // Straps held through reset and the capture edge
    task automatic boot(input logic [1:0] m);
        resetn_i = 1'b0;
        {bh, bl} = m;
        {fw, bur, uae, lsd} = 4'h0;
        cyc(8);
        check(csoe, 1'b1);
        resetn_i = 1'b1;
        cyc(3);
        check(bm, m);
    endtask
    // One-cycle write of all function fields
    task automatic cfg(input logic [2:0] a, b, c, d, input logic [23:0] p);
        {f12, f11, f10, f9, pdf, fw} = {a, b, c, d, p, 1'b1};
        cyc(1);
        fw = 1'b0;
        cyc(3);
    endtask
    task automatic t_parallel;
        boot(2'h0);
        check(csoe, 1'b0);
        check(aoe, {5'h1f, 20'h00000});
        check(weoe, 1'b1);
        check(pfoe, 4'hf);
        {rd, ba} = {1'b1, 26'h0000000};
        cyc(2);
        check(rsn, 1'b0);
        check(cs, 1'b0);
        check(ao, 25'h0000000);
        {rd, uae} = 2'h1;
        cyc(3);
        check(aoe[25:21], 5'h1f);
        bur = 1'b1;
        cyc(3);
        check(aoe, 25'h0000000);
        check(weoe, 1'b0);
        {wr, bw, ba} = {1'b1, 16'hbeef, 26'h3e00002};
        cyc(2);
        check({dout, doe}, {16'hbeef, 16'h0000});
        check(ao, 25'h1f00001);
        check(we, 1'b0);
        check({pdo, pdoe}, {12'hbee, 12'h000});
        wr = 1'b0;
    endtask
    task automatic t_nand;
        boot(2'h2);
        check(bn, 1'b1);
        {dgoe, dgo} = {12'h000, 12'ha5c};
        cyc(2);
        check({pdo, pdoe}, {12'ha5c, 12'h000});
        nd = {1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 8'h3c, 1'b1};
        cfg(3'h0, 3'h0, 3'h5, 3'h5, 24'h555555);
        check({pdo, pdoe}, {12'h3ca, 12'h000});
        check({pfo[1], pfoe[1:0]}, 3'h1);
        {creq, busy} = 2'h3;
        cyc(3);
        check({gr, rb}, 2'h0);
        busy = 1'b0;
        cyc(3);
        check({gr, rb}, 2'h3);
        nd.chip_enable_n = 1'b1;
        cyc(2);
        check({pdo, pdoe}, {12'hbee, 12'hfff});
    endtask
    task automatic t_serial;
        boot(2'h3);
        check(bs, 1'b1);
        boot(2'h1);
        check(bs, 1'b1);
        check(pfoe, 4'hf);
        {sr, lsd} = 4'hb;
        cyc(1);
        lsd = 1'b0;
        cyc(3);
        check({pfo[2:0], pfoe}, 7'h58);
        check(srd, 1'b0);
        sr.transmit_data = 1'b0;
        cyc(3);
        check(srd, 1'b1);
        {fgoe, fgo} = 8'h09;
        cfg(3'h7, 3'h7, 3'h7, 3'h7, 24'hffffff);
        check({pfo, pfoe}, 8'h90);
        check({pdo, pdoe}, {12'ha5c, 12'h000});
    endtask
    task automatic end_of_test;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // Main sequence
    initial begin
        t_parallel;
        t_nand;
        t_serial;
        end_of_test;
    end
    // Watchdog, far beyond the under one hundred cycles needed
    initial begin
        #20000;
        miscompares++;
        end_of_test;
    end
endmodule
`default_nettype wire
